// *** hdl/emac_host_ctrl.sv ***
// Operation
// RQ1: Three-bit priority code, 000 most urgent, 111 least, is written to the device.
// RQ2: Priority setting resets to 001 and is programmed during bring-up.
// RQ3: Memory must serve each 64-byte request within 0.512 us at gigabit.
// RQ4: Single memory latency stays under 0.512 us times the cell threshold.
// RQ5: Soft reset is requested by writing one to bit 0.
// RQ6: DMA engines are stopped before the soft reset is requested.
// RQ7: Soft reset bit reads one while pending, zero when done.
// RQ8: After soft reset every device register is programmed again.
// RQ9: Host error is cleared by soft or hardware reset; status saved first.
// RQ10: Hardware reset restores defaults; device idles until initialised.
// RQ11: Interrupt pace count, peripheral clock one sixth of core, is programmed.
// RQ12: Descriptors live in an 8K local RAM inside the control module.
// RQ13: Interrupt enables are cleared then set, resetting the pace counter.
// RQ14: Management clock divider is programmed for about 1 MHz or slower.
// RQ15: Preamble suppression is set only when software asks for it.
// RQ16: Management engine is enabled so it polls all 32 PHY addresses.
// RQ17: Eight transmit and eight receive queues have head pointers.
// RQ18: All 16 head descriptor pointers are zeroed before DMA enable.
// RQ19: All 36 statistics counters are cleared by writing zero.
// RQ20: All 32 address RAM locations are zeroed before matching setup.
// RQ21: Writing FFh to unicast disable clears unicast on all channels.
// RQ22: Media enable is set only after both DMA engines are enabled.
// RQ23: Soft reset bit self-clears; host polls until it reads zero.
// RQ24: Transmit cell start threshold is programmed into FIFO control.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module emac_host_ctrl
	import emac_host_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// APB slave, software side
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// APB master, device side
	output logic             m_psel,
	output logic             m_penable,
	output logic             m_pwrite,
	output logic      [15:0] m_paddr,
	output logic      [31:0] m_pwdata,
	input  wire logic [31:0] m_prdata,
	input  wire logic        m_pready
);
	import emac_host_pkg::*;

	logic [31:0]   config_reg;
	logic [15:0]   pace;
	logic [31:0]   error_status;
	logic          running;
	logic          init_done;
	step_e         step;
	logic [6:0]    idx;
	master_state_e mst;

	// Step table
	function automatic xfer_s step_xfer(input step_e s,
		input logic [6:0] i, input logic [31:0] c, input logic [15:0] p);
		xfer_s x;
		x = '{wr: 1'b1, addr: 16'h0000, data: 32'h0000_0000,
			last: 7'h00};
		unique case (s)
			ST_ERR_READ: begin
				x.wr = 1'b0;
				x.addr = DEV_MAC_ERR_STATUS;
			end
			ST_RX_OFF:    x.addr = DEV_RX_CTRL;
			ST_TX_OFF:    x.addr = DEV_TX_CTRL;
			ST_SRST: begin
				x.addr = DEV_SOFT_RESET;
				x.data[SOFT_RESET_BIT] = 1'b1;
			end
			ST_SRST_POLL: begin
				x.wr = 1'b0;
				x.addr = DEV_SOFT_RESET;
			end
			ST_INT_OFF: begin
				x.addr = DEV_CTL_INT_EN + 16'({i[1:0], 2'b00});
				x.last = LAST_INT_EN;
			end
			ST_CFG_CLR:   x.addr = DEV_MAC_CFG;
			ST_RXC_CLR:   x.addr = DEV_RX_CTRL;
			ST_TXC_CLR:   x.addr = DEV_TX_CTRL;
			ST_HDP: begin
				x.addr = DEV_HDP + 16'({i[3:0], 2'b00});
				x.last = LAST_HDP;
			end
			ST_STATS: begin
				x.addr = DEV_STATS + 16'({i[5:0], 2'b00});
				x.last = LAST_STATS;
			end
			ST_ADDR: begin
				x.addr = i[0] ? DEV_ADDR_HI : DEV_ADDR_INDEX;
				x.data = i[0] ? 32'h0000_0000 : 32'(i[5:1]);
				x.last = LAST_ADDR;
			end
			ST_UC_DIS: begin
				x.addr = DEV_UNICAST_DIS;
				x.data = UNICAST_ALL;
			end
			ST_UC_SET: begin
				x.addr = DEV_UNICAST_SET;
				x.data = 32'(c[CFG_UNICAST_LSB +: 8]);
			end
			ST_PRIO: begin
				x.addr = DEV_PRIO_ALLOC;
				x.data = 32'(c[CFG_PRIO_LSB +: 3]);
			end
			ST_FIFO: begin
				x.addr = DEV_FIFO_CTRL;
				x.data = 32'(c[CFG_THRESH_LSB +: 5]);
			end
			ST_MDIO: begin
				x.addr = DEV_MDIO_CTRL;
				x.data = 32'(c[CFG_DIV_LSB +: 8]);
				x.data[MDIO_EN_BIT] = 1'b1;
				x.data[MDIO_PREAMBLE_BIT] = c[CFG_PREAMBLE_BIT];
			end
			ST_CFG: begin
				x.addr = DEV_MAC_CFG;
			end
			ST_RX_EN: begin
				x.addr = DEV_RX_CTRL;
				x.data = DMA_ENABLE;
			end
			ST_TX_EN: begin
				x.addr = DEV_TX_CTRL;
				x.data = DMA_ENABLE;
			end
			ST_CFG_MEDIA: begin
				x.addr = DEV_MAC_CFG;
				x.data[MEDIA_EN_BIT] = 1'b1;
				x.data[GIG_SEL_BIT] = c[CFG_GIG_BIT];
			end
			ST_PACE: begin
				x.addr = DEV_CTL_PACE;
				x.data = 32'(p);
			end
			ST_INT_ON: begin
				x.addr = DEV_CTL_INT_EN + 16'({i[1:0], 2'b00});
				x.data = (i[1:0] == 2'b11) ? MISC_EN_ON : INT_EN_ON;
				x.last = LAST_INT_EN;
			end
			default: x.wr = 1'b0;
		endcase
		return x;
	endfunction : step_xfer

	// Step order
	function automatic step_e step_succ(input step_e s,
		input logic adv);
		// Hold unless the step is finished
		if (!adv)
			return s;
		unique case (s)
			ST_ERR_READ:  return ST_RX_OFF;      // RQ9
			ST_RX_OFF:    return ST_TX_OFF;      // RQ6
			ST_TX_OFF:    return ST_SRST;        // RQ6
			ST_SRST:      return ST_SRST_POLL;   // RQ5
			ST_SRST_POLL: return ST_INT_OFF;     // RQ7 RQ23
			ST_INT_OFF:   return ST_CFG_CLR;     // RQ13
			ST_CFG_CLR:   return ST_RXC_CLR;     // RQ8
			ST_RXC_CLR:   return ST_TXC_CLR;
			ST_TXC_CLR:   return ST_HDP;
			ST_HDP:       return ST_STATS;       // RQ12 RQ17 RQ18
			ST_STATS:     return ST_ADDR;        // RQ19
			ST_ADDR:      return ST_UC_DIS;      // RQ20
			ST_UC_DIS:    return ST_UC_SET;      // RQ21
			ST_UC_SET:    return ST_PRIO;        // RQ21
			ST_PRIO:      return ST_FIFO;        // RQ1 RQ2
			ST_FIFO:      return ST_MDIO;        // RQ24 RQ4
			ST_MDIO:      return ST_CFG;         // RQ14 RQ15 RQ16
			ST_CFG:       return ST_RX_EN;
			ST_RX_EN:     return ST_TX_EN;
			ST_TX_EN:     return ST_CFG_MEDIA;   // RQ22
			ST_CFG_MEDIA: return ST_PACE;        // RQ22
			ST_PACE:      return ST_INT_ON;      // RQ11
			ST_INT_ON:    return ST_DONE;        // RQ13
			ST_DONE:      return ST_DONE;
			default:      return ST_DONE;
		endcase
	endfunction : step_succ

	// Slave decode
	wire         s_setup   = psel & ~penable;
	wire         s_write   = psel & penable & pwrite;
	wire         hit_cmd   = (paddr == REG_COMMAND);
	wire         hit_cfg   = (paddr == REG_CONFIG);
	wire         hit_pace  = (paddr == REG_PACE);
	wire         hit_stat  = (paddr == REG_STATUS);
	wire         hit_err   = (paddr == REG_ERROR);
	wire         mapped    = hit_cmd | hit_cfg | hit_pace | hit_stat
		| hit_err;

	// Commands, dropped while busy
	wire         busy      = running | (mst != M_IDLE);
	wire         cmd_init  = s_write & hit_cmd & pwdata[CMD_INIT_BIT]
		& ~busy;
	wire         cmd_srst  = s_write & hit_cmd & pwdata[CMD_SRST_BIT]
		& ~busy;

	// Status word and read mux
	wire [31:0]  status    = {28'h0, step == ST_SRST_POLL, 1'b0,
		init_done, busy};
	wire [31:0]  rd_mux    = hit_cfg  ? config_reg :
		hit_pace ? 32'(pace) :
		hit_stat ? status :
		hit_err  ? error_status : 32'h0000_0000;

	// Sequencer decode
	wire xfer_s  cur       = step_xfer(step, idx, config_reg, pace);
	wire         xfer_end  = (mst == M_ACCESS) & m_pready;
	wire         step_last = (idx == cur.last);
	// Poll repeats until the device clears its bit
	wire         poll_busy = (step == ST_SRST_POLL)
		& m_prdata[SOFT_RESET_BIT];                      // RQ7 RQ23
	wire step_e  next_step = step_succ(step,
		step_last & ~poll_busy);
	wire [6:0]   next_idx  = (poll_busy | step_last) ? 7'h00
		: idx + 7'h01;

	// Software registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			config_reg <= CONFIG_RESET;                      // RQ2
			pace       <= PACE_RESET;
		end else begin
			if (s_write & hit_cfg)
				config_reg <= pwdata;
			if (s_write & hit_pace)
				pace <= pwdata[15:0];
		end
	end

	// Slave answer, zero wait states
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (s_setup) begin
				prdata  <= rd_mux;
				pslverr <= ~mapped;
			end
		end
	end

	// Step sequencer
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			running   <= 1'b0;                               // RQ10
			init_done <= 1'b0;
			step      <= ST_DONE;
			idx       <= 7'h00;
		end else if (cmd_init) begin
			running   <= 1'b1;
			init_done <= 1'b0;
			step      <= ST_INT_OFF;                         // RQ13
			idx       <= 7'h00;
		end else if (cmd_srst) begin
			running   <= 1'b1;
			init_done <= 1'b0;
			step      <= ST_ERR_READ;                        // RQ9
			idx       <= 7'h00;
		end else if (xfer_end) begin
			step <= next_step;                               // RQ8
			idx  <= next_idx;
			if (next_step == ST_DONE) begin
				running   <= 1'b0;
				init_done <= 1'b1;
			end
		end
	end

	// Error status captured before reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			error_status <= 32'h0000_0000;
		else if (xfer_end & (step == ST_ERR_READ))
			error_status <= m_prdata;                        // RQ9
	end

	// APB master
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mst       <= M_IDLE;
			m_psel    <= 1'b0;
			m_penable <= 1'b0;
			m_pwrite  <= 1'b0;
			m_paddr   <= 16'h0000;
			m_pwdata  <= 32'h0000_0000;
		end else begin
			unique case (mst)
				M_IDLE: begin
					if (running & (step != ST_DONE)) begin
						mst      <= M_SETUP;
						m_psel   <= 1'b1;
						m_pwrite <= cur.wr;
						m_paddr  <= cur.addr;
						m_pwdata <= cur.data;
					end
				end
				M_SETUP: begin
					mst       <= M_ACCESS;
					m_penable <= 1'b1;
				end
				M_ACCESS: begin
					if (m_pready) begin
						mst       <= M_IDLE;
						m_psel    <= 1'b0;
						m_penable <= 1'b0;
					end
				end
			endcase
		end
	end

	// Step order notes, carried by the table above:
	// stop DMA before reset                                 RQ6
	// write reset bit                                       RQ5
	// zero head pointers                                    RQ17 RQ18
	// clear statistics                                      RQ19
	// zero address RAM                                      RQ20
	// unicast disable all                                   RQ21
	// priority code                                         RQ1
	// cell threshold                                        RQ24 RQ4
	// divider, enable, preamble                             RQ14 RQ15 RQ16
	// media enable after DMA enables                        RQ22
	// pace count                                            RQ11
endmodule : emac_host_ctrl
`default_nettype wire

// *** hdl/emac_host_pkg.sv ***
`default_nettype none
package emac_host_pkg;
	// Own register offsets (APB byte addresses)
	localparam logic [7:0]  REG_COMMAND        = 8'h00;
	localparam logic [7:0]  REG_CONFIG         = 8'h04;
	localparam logic [7:0]  REG_PACE           = 8'h08;
	localparam logic [7:0]  REG_STATUS         = 8'h0c;
	localparam logic [7:0]  REG_ERROR          = 8'h10;
	// Own field positions
	localparam int          CMD_INIT_BIT       = 0;
	localparam int          CMD_SRST_BIT       = 1;
	localparam int          CFG_PRIO_LSB       = 0;
	localparam int          CFG_PREAMBLE_BIT   = 3;
	localparam int          CFG_GIG_BIT        = 4;
	localparam int          CFG_THRESH_LSB     = 8;
	localparam int          CFG_DIV_LSB        = 16;
	localparam int          CFG_UNICAST_LSB    = 24;
	// Own reset values
	localparam logic [31:0] CONFIG_RESET       = 32'h007d_1801;
	localparam logic [15:0] PACE_RESET         = 16'h0004;
	// Device register offsets
	localparam logic [15:0] DEV_CTL_PACE       = 16'h000c;
	localparam logic [15:0] DEV_CTL_INT_EN     = 16'h0014;
	localparam logic [15:0] DEV_TX_CTRL        = 16'h1004;
	localparam logic [15:0] DEV_RX_CTRL        = 16'h1014;
	localparam logic [15:0] DEV_UNICAST_SET    = 16'h1108;
	localparam logic [15:0] DEV_UNICAST_DIS    = 16'h110c;
	localparam logic [15:0] DEV_MAC_CFG        = 16'h1160;
	localparam logic [15:0] DEV_MAC_ERR_STATUS = 16'h1164;
	localparam logic [15:0] DEV_FIFO_CTRL      = 16'h1170;
	localparam logic [15:0] DEV_SOFT_RESET     = 16'h1174;
	localparam logic [15:0] DEV_STATS          = 16'h1200;
	localparam logic [15:0] DEV_ADDR_INDEX     = 16'h1500;
	localparam logic [15:0] DEV_ADDR_HI        = 16'h1504;
	localparam logic [15:0] DEV_HDP            = 16'h1600;
	localparam logic [15:0] DEV_PRIO_ALLOC     = 16'h8000;
	localparam logic [15:0] DEV_MDIO_CTRL      = 16'h4004;
	// Device field positions and values
	localparam int          SOFT_RESET_BIT     = 0;
	localparam logic [31:0] DMA_ENABLE         = 32'h0000_0001;
	localparam int          MEDIA_EN_BIT       = 5;
	localparam int          GIG_SEL_BIT        = 7;
	localparam int          MDIO_EN_BIT        = 30;
	localparam int          MDIO_PREAMBLE_BIT  = 20;
	localparam logic [31:0] UNICAST_ALL        = 32'h0000_00ff;
	localparam logic [31:0] INT_EN_ON          = 32'h0000_00ff;
	localparam logic [31:0] MISC_EN_ON         = 32'h0000_000f;
	// Counts less one
	localparam logic [6:0]  LAST_INT_EN        = 7'h03;
	localparam logic [6:0]  LAST_HDP           = 7'h0f;
	localparam logic [6:0]  LAST_STATS         = 7'h23;
	localparam logic [6:0]  LAST_ADDR          = 7'h3f;
	// Sequence steps, Gray coded in run order
	typedef enum logic [4:0] {
		ST_ERR_READ  = 5'h00,
		ST_RX_OFF    = 5'h01,
		ST_TX_OFF    = 5'h03,
		ST_SRST      = 5'h02,
		ST_SRST_POLL = 5'h06,
		ST_INT_OFF   = 5'h07,
		ST_CFG_CLR   = 5'h05,
		ST_RXC_CLR   = 5'h04,
		ST_TXC_CLR   = 5'h0c,
		ST_HDP       = 5'h0d,
		ST_STATS     = 5'h0f,
		ST_ADDR      = 5'h0e,
		ST_UC_DIS    = 5'h0a,
		ST_UC_SET    = 5'h0b,
		ST_PRIO      = 5'h09,
		ST_FIFO      = 5'h08,
		ST_MDIO      = 5'h18,
		ST_CFG       = 5'h19,
		ST_RX_EN     = 5'h1b,
		ST_TX_EN     = 5'h1a,
		ST_CFG_MEDIA = 5'h1e,
		ST_PACE      = 5'h1f,
		ST_INT_ON    = 5'h1d,
		ST_DONE      = 5'h1c
	} step_e;

	typedef enum logic [1:0] {
		M_IDLE   = 2'b00,
		M_SETUP  = 2'b01,
		M_ACCESS = 2'b11
	} master_state_e;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [31:0] data;
		logic [6:0]  last;
	} xfer_s;
endpackage : emac_host_pkg
`default_nettype wire

// *** sim/emac_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module emac_dev_model
	import emac_host_pkg::*;
(
	// Clock and reset
	input wire logic	clk_sys,
	input wire logic	reset,
	// Bus from controller
	input wire logic	m_psel,
	input wire logic	m_penable,
	input wire logic	m_pwrite,
	input wire logic [15:0]	m_paddr,
	input wire logic [31:0]	m_pwdata,
	output logic [31:0]	m_prdata,
	output logic	m_pready,
	// Scenario control
	input wire logic	slow
);
	logic [31:0]	mem [int];
	int	wait_n = 0, srst_left = 0, cyc = 0;
	int	order_bad = 0, polls = 0, n_srst = 0;
	function automatic logic [31:0] peek(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : 32'h0;
	endfunction
	// Stale state from earlier traffic
	task soil;
		for (int i = 0; i < 36; i++) begin
			mem[DEV_STATS + 16'(4 * i)] = 32'h1;
			mem[DEV_HDP + 16'(4 * i)] = 32'h1;
		end
		mem[DEV_ADDR_HI] = 32'h1;
		mem[DEV_RX_CTRL] = DMA_ENABLE;
		mem[DEV_TX_CTRL] = DMA_ENABLE;
		mem[DEV_MAC_ERR_STATUS] = 32'h0000_0bad;
	endtask : soil
	assign m_pready = m_psel && m_penable &&
		wait_n >= (slow ? 3 : 0);
	assign m_prdata = !m_pready ? {cyc[15:0], ~cyc[15:0]} :
		m_paddr == DEV_SOFT_RESET ? {31'h0, srst_left != 0} :
		peek(m_paddr);
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mem.delete();
			mem[DEV_PRIO_ALLOC] = 32'h1;
			srst_left <= 0;
			wait_n <= 0;
		end else begin
			cyc++;
			if (srst_left == 1) begin
				mem.delete();
				mem[DEV_PRIO_ALLOC] = 32'h1;
			end
			if (srst_left > 0)
				srst_left <= srst_left - 1;
			wait_n <= (m_psel && m_penable && !m_pready) ? wait_n + 1 : 0;
			if (m_pready && !m_pwrite && m_paddr == DEV_SOFT_RESET &&
				srst_left != 0)
				polls++;
			if (m_pready && m_pwrite) begin
				mem[m_paddr] = m_pwdata;
				if (m_paddr == DEV_UNICAST_DIS)
					mem[DEV_UNICAST_SET] =
						peek(DEV_UNICAST_SET) & ~m_pwdata;
				if (m_paddr == DEV_SOFT_RESET && m_pwdata[SOFT_RESET_BIT]) begin
					n_srst++;
					srst_left <= 6;
					if (peek(DEV_RX_CTRL) != 0 || peek(DEV_TX_CTRL) != 0)
						order_bad++;
				end
				if (m_paddr == DEV_MAC_CFG && m_pwdata[MEDIA_EN_BIT] &&
					(peek(DEV_RX_CTRL) != DMA_ENABLE ||
					peek(DEV_TX_CTRL) != DMA_ENABLE))
					order_bad++;
				if ((m_paddr == DEV_RX_CTRL || m_paddr == DEV_TX_CTRL) &&
					m_pwdata[0])
					for (int i = 0; i < 16; i++)
						if (peek(DEV_HDP + 16'(4 * i)) != 0)
							order_bad++;
			end
		end
	end
endmodule : emac_dev_model
`default_nettype wire

// *** sim/emac_host_ctrl_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module emac_host_ctrl_bench;
	import emac_host_pkg::*;
	logic	clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic	slow = 0, pready, pslverr, m_psel, m_penable, m_pwrite, m_pready;
	logic [7:0]	paddr = 0;
	logic [15:0]	m_paddr;
	logic [31:0]	pwdata = 0, prdata, m_prdata, m_pwdata, rd, err;
	int	err_total = 0, n_tests = 0, cyc = 0;
	always #20 clk_sys = ~clk_sys;
	emac_host_ctrl i_dut (.clk_sys, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .m_psel, .m_penable,
		.m_pwrite, .m_paddr, .m_pwdata, .m_prdata, .m_pready);
	emac_dev_model i_dev (.clk_sys, .reset, .m_psel, .m_penable, .m_pwrite,
		.m_paddr, .m_pwdata, .m_prdata, .m_pready, .slow);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task close_out;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task wait_idle;
		rd = 32'h1;
		for (int k = 0; k < 5000 && rd[0] !== 1'b0; k++)
			apb(1'b0, REG_STATUS, 32'h0);
	endtask : wait_idle
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, REG_CONFIG, 32'h0);
		check(rd, CONFIG_RESET);
		apb(1'b0, REG_PACE, 32'h0);
		check(rd, {16'h0, PACE_RESET});
		apb(1'b1, 8'h14, 32'hffff_ffff);
		check(err, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h0);
		check(i_dev.peek(DEV_PRIO_ALLOC), 32'h1);
		$display("done: reset values");
		i_dev.soil();
		apb(1'b1, REG_CONFIG, 32'h5a40_101d);
		apb(1'b1, REG_PACE, 32'h0000_0003);
		apb(1'b1, REG_COMMAND, 32'h1);
		apb(1'b1, REG_COMMAND, 32'h2);
		wait_idle();
		check({30'h0, rd[1:0]}, 32'h2);
		check(i_dev.peek(DEV_PRIO_ALLOC), 32'h5);
		check(i_dev.peek(DEV_UNICAST_SET), 32'h5a);
		check(i_dev.peek(DEV_MDIO_CTRL), 32'h4010_0040);
		check(i_dev.peek(DEV_MAC_CFG), 32'ha0);
		check(i_dev.peek(DEV_CTL_PACE), 32'h3);
		check(i_dev.peek(DEV_FIFO_CTRL), 32'h10);
		check(i_dev.peek(DEV_CTL_INT_EN + 16'hc), MISC_EN_ON);
		check(i_dev.peek(DEV_ADDR_HI), 32'h0);
		for (int i = 0; i < 36; i++)
			check(i_dev.peek(DEV_STATS + 16'(4 * i)), 32'h0);
		check(32'(i_dev.order_bad), 32'h0);
		$display("done: bring-up");
		slow <= 1'b1;
		i_dev.soil();
		apb(1'b1, REG_COMMAND, 32'h2);
		wait_idle();
		apb(1'b0, REG_ERROR, 32'h0);
		check(rd, 32'h0000_0bad);
		check(i_dev.peek(DEV_MAC_ERR_STATUS), 32'h0);
		check(32'(i_dev.n_srst), 32'h1);
		check(32'(i_dev.polls != 0), 32'h1);
		check(i_dev.peek(DEV_PRIO_ALLOC), 32'h5);
		check(32'(i_dev.order_bad), 32'h0);
		$display("done: soft reset");
		apb(1'b1, REG_COMMAND, 32'h1);
		repeat (5) @(posedge clk_sys);
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h0);
		check({31'h0, m_psel}, 32'h0);
		apb(1'b0, REG_CONFIG, 32'h0);
		check(rd, CONFIG_RESET);
		$display("done: hardware reset");
		close_out();
	end
endmodule : emac_host_ctrl_bench
bind emac_host_ctrl emac_host_ctrl_sva i_sva (.clk_sys, .reset, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .m_psel,
	.m_penable, .m_pwrite, .m_paddr, .m_pwdata, .m_pready);
`default_nettype wire

// *** sim/emac_host_ctrl_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module emac_host_ctrl_sva
	import emac_host_pkg::*;
(
	// Clock and reset
	input wire logic	clk_sys,
	input wire logic	reset,
	// Software side
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// Device side
	input wire logic	m_psel,
	input wire logic	m_penable,
	input wire logic	m_pwrite,
	input wire logic [15:0]	m_paddr,
	input wire logic [31:0]	m_pwdata,
	input wire logic	m_pready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic	cfg_wr;
	wire	acc = psel && penable;
	wire	m_wr = m_psel && m_penable && m_pready && m_pwrite;
	wire	bad = paddr > REG_ERROR || paddr[1:0] != 2'b00;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			cfg_wr <= 1'b0;
		else if (acc && pwrite && paddr == REG_CONFIG)
			cfg_wr <= 1'b1;
	end
	sequence s_setup; m_psel && !m_penable; endsequence
	sequence s_wait; m_psel && m_penable && !m_pready; endsequence
	sequence s_done; m_psel && m_penable && m_pready; endsequence
	a_slave_no_wait: assert property (acc |-> pready)
		else $error("slave access stalled");
	a_unmapped_err: assert property (acc && bad |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && !bad |-> !pslverr)
		else $error("mapped access refused");
	a_config_default: assert property
		(acc && !pwrite && paddr == REG_CONFIG && !cfg_wr |->
		prdata == CONFIG_RESET) else $error("config default wrong");
	a_setup_access: assert property (s_setup |=> m_psel && m_penable &&
		$stable(m_paddr) && $stable(m_pwdata) && $stable(m_pwrite))
		else $error("setup not followed by access");
	a_hold_wait: assert property (s_wait |=> m_psel && m_penable &&
		$stable(m_paddr) && $stable(m_pwdata)) else $error("request moved");
	a_idle_after: assert property (s_done |=> !m_psel)
		else $error("no idle cycle");
	a_prio_code: assert property
		(m_wr && m_paddr == DEV_PRIO_ALLOC |-> m_pwdata[31:3] == 29'h0)
		else $error("priority outside field");
	a_unicast_all: assert property
		(m_wr && m_paddr == DEV_UNICAST_DIS |-> m_pwdata == UNICAST_ALL)
		else $error("unicast disable not all");
	a_srst_bit: assert property
		(m_wr && m_paddr == DEV_SOFT_RESET |-> m_pwdata[SOFT_RESET_BIT])
		else $error("soft reset without bit 0");
endmodule : emac_host_ctrl_sva
`default_nettype wire
